// ==== prc_rx_control.sv ====
// Receive control, ack wait timer and transmitter power-down delay
`timescale 1ns/1ps
`default_nettype none
module prc_rx_control
    import prc_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        mac_software_reset_in,
    input  wire logic        protocol_reset_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        tx_request_in,
    input  wire logic        tx_start_in,
    input  wire logic        tx_end_in,
    input  wire logic        tx_test_mode_in,
    input  wire logic        auto_response_enable_in,
    input  wire logic [2:0]  retry_limit_in,
    input  wire logic        wait_for_ack_in,
    input  wire logic        ack_received_in,
    input  wire logic        rx_busy_in,
    input  wire logic        hard_reset_seen_in,
    input  wire logic        cable_reset_seen_in,
    output logic             tx_power_out,
    output logic             rx_active_out,
    output logic             rx_queue_reset_out,
    output logic             loopback_out,
    output logic             hdr_len_first_out,
    output logic             cable_detect_out,
    output logic             reset_rx_allowed_out,
    output logic             ack_wait_timeout_flag_out,
    output logic             irq_out
);
    import prc_pkg::*;

    typedef enum logic [1:0] {PRC_PD_IDLE, PRC_PD_ON, PRC_PD_DELAY} prc_pd_t;

    logic       soft_rst;
    logic [7:0] pd_delay_reg;
    logic [5:0] ctl_reg;
    logic       rx_en_reg;
    logic       rx_en_pend_reg;
    logic       rx_en_req_reg;
    logic       armed_reg;
    logic [7:0] tmr_load_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_set;
    logic       tmr_run_reg;
    logic       tmr_expired_reg;
    logic [7:0] tmr_cnt_reg;
    logic [5:0] tmr_pre_reg;
    logic       tmr_enabled;
    prc_pd_t    pd_state_reg;
    logic [10:0] pd_cnt_reg;
    logic       wr_ctl;
    logic       hard_rx;
    logic       cable_rx;

    assign soft_rst = sys_rst_in | mac_software_reset_in;
    assign wr_ctl   = reg_wr_in && reg_addr_in == PRC_ADDR_RX_CONTROL_A;

    assign hard_rx  = armed_reg & hard_reset_seen_in;
    assign cable_rx = armed_reg & ctl_reg[PRC_BIT_CABLE_DET]
                      & cable_reset_seen_in;

    assign tmr_enabled = ctl_reg[PRC_BIT_TMR_EN]
        | (auto_response_enable_in & (retry_limit_in != 3'h0))
        | (wait_for_ack_in & (retry_limit_in == 3'h0));

    // Configuration registers
    always_ff @(posedge clk_sys_in)
    begin
        if (soft_rst)
        begin
            pd_delay_reg <= PRC_RST_PD_DELAY;
            ctl_reg      <= 6'h00;
            tmr_load_reg <= PRC_RST_TMR_LOAD;
            irq_mask_reg <= 3'h0;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                PRC_ADDR_PD_DELAY: pd_delay_reg <= reg_wdata_in;
                PRC_ADDR_RX_CONTROL_A: ctl_reg <= reg_wdata_in[5:0];
                PRC_ADDR_TMR_LOAD: tmr_load_reg <= reg_wdata_in;
                PRC_ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata_in[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (soft_rst)
        begin
            rx_en_reg      <= 1'b0;
            rx_en_pend_reg <= 1'b0;
            rx_en_req_reg  <= 1'b0;
        end
        else
        begin
            if (hard_rx | cable_rx)
            begin
                rx_en_pend_reg <= 1'b0;
                rx_en_reg      <= 1'b0;
            end
            else if (wr_ctl & rx_busy_in)
            begin
                rx_en_pend_reg <= 1'b1;
                rx_en_req_reg  <= reg_wdata_in[PRC_BIT_RX_EN];
            end
            else if (wr_ctl)
            begin
                rx_en_reg      <= reg_wdata_in[PRC_BIT_RX_EN];
                rx_en_pend_reg <= 1'b0;
            end
            else if (rx_en_pend_reg & ~rx_busy_in)
            begin
                rx_en_reg      <= rx_en_req_reg;
                rx_en_pend_reg <= 1'b0;
            end
        end
    end

    // reset reception armed once enable first set
    always_ff @(posedge clk_sys_in)
    begin
        if (soft_rst)
            armed_reg <= 1'b0;
        else if (rx_en_reg)
            armed_reg <= 1'b1;
    end

    // ack wait timer in microsecond ticks
    always_ff @(posedge clk_sys_in)
    begin
        if (soft_rst | protocol_reset_in)
        begin
            tmr_run_reg     <= 1'b0;
            tmr_expired_reg <= 1'b0;
            tmr_cnt_reg     <= 8'h00;
            tmr_pre_reg     <= 6'h00;
        end
        else if (tx_start_in)
        begin
            tmr_run_reg     <= 1'b0;
            tmr_expired_reg <= 1'b0;
            tmr_cnt_reg     <= tmr_load_reg;
            tmr_pre_reg     <= 6'h00;
        end
        else if (tx_end_in & tmr_enabled & ~tmr_expired_reg)
        begin
            tmr_run_reg <= 1'b1;
            tmr_cnt_reg <= tmr_load_reg;
            tmr_pre_reg <= 6'h00;
        end
        else if (tmr_run_reg & (~tmr_enabled | ack_received_in))
            tmr_run_reg <= 1'b0;
        else if (tmr_run_reg)
        begin
            if (tmr_pre_reg == 6'(PRC_TMR_UNIT_CLKS - 1))
            begin
                tmr_pre_reg <= 6'h00;
                if (tmr_cnt_reg == 8'h00)
                begin
                    tmr_run_reg     <= 1'b0;
                    tmr_expired_reg <= 1'b1;
                end
                else
                    tmr_cnt_reg <= tmr_cnt_reg - 8'h01;
            end
            else
                tmr_pre_reg <= tmr_pre_reg + 6'h01;
        end
    end

    assign irq_set = {cable_rx, hard_rx,
        tmr_run_reg & tmr_enabled & ~ack_received_in
        & (tmr_pre_reg == 6'(PRC_TMR_UNIT_CLKS - 1))
        & (tmr_cnt_reg == 8'h00)};

    // sticky status, set wins over clear
    always_ff @(posedge clk_sys_in)
    begin
        if (soft_rst)
            irq_stat_reg <= 3'h0;
        else if (reg_wr_in && reg_addr_in == PRC_ADDR_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~reg_wdata_in[2:0]) | irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (soft_rst)
        begin
            pd_state_reg <= PRC_PD_IDLE;
            pd_cnt_reg   <= 11'h000;
        end
        else
        begin
            case (pd_state_reg)
                PRC_PD_IDLE:
                    if (tx_request_in | tx_start_in)
                        pd_state_reg <= PRC_PD_ON;
                PRC_PD_ON:
                    if (tx_end_in)
                    begin
                        pd_state_reg <= PRC_PD_DELAY;
                        pd_cnt_reg   <= 11'({pd_delay_reg, 3'h0})
                            + 11'(PRC_PD_EXTRA_CLKS - 1);
                    end
                PRC_PD_DELAY:
                    if (tx_request_in | tx_start_in)
                        pd_state_reg <= PRC_PD_ON;
                    else if (pd_cnt_reg == 11'h000)
                        pd_state_reg <= PRC_PD_IDLE;
                    else
                        pd_cnt_reg <= pd_cnt_reg - 11'h001;
                default: pd_state_reg <= PRC_PD_IDLE;
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            tx_power_out              <= 1'b0;
            rx_active_out             <= 1'b0;
            rx_queue_reset_out        <= 1'b1;
            loopback_out              <= 1'b0;
            hdr_len_first_out         <= 1'b0;
            cable_detect_out          <= 1'b0;
            reset_rx_allowed_out      <= 1'b0;
            ack_wait_timeout_flag_out <= 1'b0;
            irq_out                   <= 1'b0;
        end
        else
        begin
            tx_power_out  <= pd_state_reg != PRC_PD_IDLE;
            rx_active_out <= rx_en_reg;
            rx_queue_reset_out <= ctl_reg[PRC_BIT_RX_RST] | protocol_reset_in
                | mac_software_reset_in;
            loopback_out      <= ctl_reg[PRC_BIT_LOOPBACK];
            hdr_len_first_out <= ctl_reg[PRC_BIT_HDR_FMT];
            cable_detect_out  <= armed_reg & ctl_reg[PRC_BIT_CABLE_DET];
            reset_rx_allowed_out      <= armed_reg;
            ack_wait_timeout_flag_out <= irq_stat_reg[PRC_IRQ_TIMEOUT];
            // Mask bit set hides the matching status bit
            irq_out <= |(irq_stat_reg & ~irq_mask_reg);
        end
    end

    // Register read port
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in | ~reg_rd_in)
            reg_rdata_out <= 8'h00;
        else
        begin
            case (reg_addr_in)
                PRC_ADDR_PD_DELAY: reg_rdata_out <= pd_delay_reg;
                PRC_ADDR_RX_CONTROL_A:
                    reg_rdata_out <= {2'h0, ctl_reg[5], rx_en_reg,
                                      ctl_reg[3:0]};
                PRC_ADDR_STATUS:
                    reg_rdata_out <= {4'h0, rx_en_pend_reg, armed_reg,
                                      tmr_expired_reg, tmr_run_reg};
                PRC_ADDR_IRQ_STAT: reg_rdata_out <= {5'h00, irq_stat_reg};
                PRC_ADDR_IRQ_MASK: reg_rdata_out <= {5'h00, irq_mask_reg};
                PRC_ADDR_TMR_LOAD: reg_rdata_out <= tmr_load_reg;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    chk_hard_clears_en: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst) hard_rx |=> !rx_en_reg)
        else $error("enable not cleared by hard reset");
    chk_unarmed_ignore: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst) !armed_reg |=>
        !$rose(irq_stat_reg[PRC_IRQ_HARD_RST])
        && !$rose(irq_stat_reg[PRC_IRQ_CABLE_RST]))
        else $error("reset received while unarmed");
    chk_en_deferred: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst) rx_busy_in && !hard_rx && !cable_rx
        && !(wr_ctl) |=> $stable(rx_en_reg))
        else $error("enable changed during reception");
    chk_timeout_flag: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst) irq_set[0] |=> irq_stat_reg[0] ##1
        ack_wait_timeout_flag_out)
        else $error("timeout flag missing");
    chk_expired_hold: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst | protocol_reset_in)
        tmr_expired_reg && !tx_start_in |=> tmr_expired_reg)
        else $error("expiry dropped early");
    chk_pd_keeps_en: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst) protocol_reset_in && !wr_ctl && !rx_en_pend_reg
        && !hard_rx && !cable_rx |=> $stable(rx_en_reg))
        else $error("enable lost on protocol reset");
    chk_queue_reset: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in) ctl_reg[PRC_BIT_RX_RST] |=> rx_queue_reset_out)
        else $error("queue not reset");
    // Last delay cycle followed by power-off state
    sequence prc_pd_tail_s;
        pd_state_reg == PRC_PD_DELAY ##1 pd_state_reg == PRC_PD_IDLE;
    endsequence
    chk_pd_delay_len: assert property (@(posedge clk_sys_in)
        disable iff (soft_rst) pd_state_reg == PRC_PD_ON && tx_end_in
        && pd_delay_reg == 8'h00 |=> ##1 prc_pd_tail_s)
        else $error("power-down delay wrong");
endmodule : prc_rx_control
`default_nettype wire

// ==== prc_pkg.sv ====
// Package with register map, field positions and timing constants
//
// Contract
// - Transmitter stays powered for programmed delay times 8 clocks plus 2.
// - Loopback bit 5 routes own transmission into the receiver.
// - Receiver enable bit 4 changes take effect only after current reception.
// - Hard or Cable Reset reception clears receiver enable automatically.
// - Hard/Cable Reset reception disabled after reset until enable first set.
// - Protocol reset leaves receiver enable unchanged.
// - Receiver reset bit 3 holds receive queue in reset while set.
// - Protocol reset also resets receiver hardware.
// - Timer auto-enabled by auto-response with retries or ack wait no retries.
// - Timer expiry without acknowledge sets timeout flag and interrupt.
// - Enabled timer starts at transmission end; software disables on ack.
// - Expired timer stays expired until next transmission start reloads it.
// - Same timer serves as test receive error timer in test transmissions; tx_test_mode_in is unused, so the timer runs alike in every transmission.
// - Bit 1 selects FIFO header order: status/length or length+1/status.
// - Cable Reset detection only when bit 0 is set.
package prc_pkg;
    localparam logic [15:0] PRC_ADDR_PD_DELAY  = 16'h1A0C;
    localparam logic [15:0] PRC_ADDR_RX_CONTROL_A  = 16'h1A40;
    localparam logic [15:0] PRC_ADDR_STATUS    = 16'h1A50;
    localparam logic [15:0] PRC_ADDR_IRQ_STAT  = 16'h1A51;
    localparam logic [15:0] PRC_ADDR_IRQ_MASK  = 16'h1A52;
    localparam logic [15:0] PRC_ADDR_TMR_LOAD  = 16'h1A53;
    localparam logic [7:0]  PRC_RST_PD_DELAY   = 8'h00;
    localparam logic [7:0]  PRC_RST_TMR_LOAD   = 8'h24;
    localparam int          PRC_BIT_CABLE_DET  = 0;
    localparam int          PRC_BIT_HDR_FMT    = 1;
    localparam int          PRC_BIT_TMR_EN     = 2;
    localparam int          PRC_BIT_RX_RST     = 3;
    localparam int          PRC_BIT_RX_EN      = 4;
    localparam int          PRC_BIT_LOOPBACK   = 5;
    localparam int          PRC_IRQ_TIMEOUT    = 0;
    localparam int          PRC_IRQ_HARD_RST   = 1;
    localparam int          PRC_IRQ_CABLE_RST  = 2;
    localparam int          PRC_PD_UNIT_CLKS   = 8;
    localparam int          PRC_PD_EXTRA_CLKS  = 2;
    localparam int          PRC_TMR_UNIT_NS    = 1000;
    localparam int          PRC_CLK_PERIOD_NS  = 25;
    localparam int          PRC_TMR_UNIT_CLKS  =
        PRC_TMR_UNIT_NS / PRC_CLK_PERIOD_NS;
endpackage : prc_pkg

// ==== prc_far_side.sv ====
// Remote port partner model driving line activity and events
`timescale 1ns/1ps
`default_nettype none
module prc_far_side (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       go_in,
    input  wire logic [1:0] kind_in,
    input  wire logic [7:0] len_in,
    output logic            busy_out,
    output logic            ack_out,
    output logic            hard_out,
    output logic            cable_out
);
    logic [7:0] cnt_reg;
    logic [1:0] kind_reg;
    always_ff @(posedge clk_in)
    begin
        ack_out   <= 1'b0;
        hard_out  <= 1'b0;
        cable_out <= 1'b0;
        if (rst_in)
        begin
            cnt_reg  <= 8'h00;
            kind_reg <= 2'h0;
        end
        else if (go_in)
        begin
            cnt_reg  <= len_in;
            kind_reg <= kind_in;
        end
        else if (cnt_reg != 8'h00)
        begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01)
            begin
                ack_out   <= (kind_reg == 2'h1);
                hard_out  <= (kind_reg == 2'h2);
                cable_out <= (kind_reg == 2'h3);
            end
        end
    end
    // Line counts as busy for the whole frame
    assign busy_out = (cnt_reg != 8'h00);
endmodule // prc_far_side
`default_nettype wire

// ==== prc_rx_control_tb.sv ====
// Self-checking testbench for the receive control block
`timescale 1ns/1ps
`default_nettype none
module prc_rx_control_tb;
    import prc_pkg::*;
    logic        clk_sys_in, sys_rst_in, sw_rst, prot_rst, wr, rd;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, rv, v, f_len;
    logic        tx_req, tx_start, tx_end, test_mode, auto_rsp, wait_ack;
    logic [2:0]  retry;
    logic        ack, busy, hard, cable, f_go;
    logic        pwr, rx_act, q_rst, loop_o, hdr_o, cab_o, allow, tmo, irq;
    logic [1:0]  f_kind;
    logic [4:0]  tc [5] = '{5'h10, 5'h0E, 5'h05, 5'h0C, 5'h08};
    int          err_total, checked, n, d, e;

    prc_rx_control DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .mac_software_reset_in(sw_rst), .protocol_reset_in(prot_rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .tx_request_in(tx_req),
        .tx_start_in(tx_start), .tx_end_in(tx_end),
        .tx_test_mode_in(test_mode), .auto_response_enable_in(auto_rsp),
        .retry_limit_in(retry), .wait_for_ack_in(wait_ack),
        .ack_received_in(ack), .rx_busy_in(busy),
        .hard_reset_seen_in(hard), .cable_reset_seen_in(cable),
        .tx_power_out(pwr), .rx_active_out(rx_act),
        .rx_queue_reset_out(q_rst), .loopback_out(loop_o),
        .hdr_len_first_out(hdr_o), .cable_detect_out(cab_o),
        .reset_rx_allowed_out(allow), .ack_wait_timeout_flag_out(tmo),
        .irq_out(irq));
    prc_far_side FAR (.clk_in(clk_sys_in), .rst_in(sys_rst_in),
        .go_in(f_go), .kind_in(f_kind), .len_in(f_len), .busy_out(busy),
        .ack_out(ack), .hard_out(hard), .cable_out(cable));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    function automatic int pd_clks(input int dly);
        return dly * PRC_PD_UNIT_CLKS + PRC_PD_EXTRA_CLKS;
    endfunction
    function automatic int tmo_clks(input int load);
        return (load + 1) * PRC_TMR_UNIT_CLKS;
    endfunction
    // Case code: b4 software enable, b3 auto response, b2 ack wait, b1:0 retry
    function automatic logic tmr_on(input logic [4:0] c);
        return c[4] | (c[3] & (c[1:0] != 2'h0)) | (c[2] & (c[1:0] == 2'h0));
    endfunction

    task automatic chk(input string nm, input logic [7:0] ex,
                       input logic [7:0] got);
        checked++;
        if (got !== ex)
        begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] dv);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= dv;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a);
        @(posedge clk_sys_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_in);
        rd   <= 1'b0;
        #1;
        rv = rdata;
    endtask
    task automatic frame(input logic [1:0] k, input logic [7:0] len,
                         input bit wait_end);
        @(posedge clk_sys_in);
        f_kind <= k;
        f_len  <= len;
        f_go   <= 1'b1;
        @(posedge clk_sys_in);
        f_go   <= 1'b0;
        if (wait_end)
            cyc(len + 3);
    endtask
    task automatic tx_frame();
        @(posedge clk_sys_in);
        tx_start <= 1'b1;
        @(posedge clk_sys_in);
        tx_start <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        tx_end <= 1'b1;
        @(posedge clk_sys_in);
        tx_end <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        {sw_rst, prot_rst, wr, rd, tx_req, tx_start, tx_end} = '0;
        {test_mode, auto_rsp, wait_ack, f_go, f_kind, retry} = '0;
        {addr, wdata, f_len} = '0;
        err_total = 0;
        checked = 0;
        sys_rst_in = 1'b1;
        e = $urandom(32'h345478a0);
        cyc(5);
        sys_rst_in <= 1'b0;
        cyc(2);
        rd_reg(PRC_ADDR_PD_DELAY);
        chk("delay reset", PRC_RST_PD_DELAY, rv);
        rd_reg(PRC_ADDR_TMR_LOAD);
        chk("load reset", PRC_RST_TMR_LOAD, rv);
        wr_reg(16'h1FFF, 8'hA5);
        rd_reg(16'h1FFF);
        chk("unmapped", 8'h00, rv);
        chk("allow reset", 8'h00, {7'h00, allow});
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom) & 8'h2F;
            wr_reg(PRC_ADDR_RX_CONTROL_A, v);
            cyc(2);
            chk("loopback", {7'h00, v[5]}, {7'h00, loop_o});
            chk("queue reset", {7'h00, v[3]}, {7'h00, q_rst});
            chk("hdr fmt", {7'h00, v[1]}, {7'h00, hdr_o});
            chk("cable det unarmed", 8'h00, {7'h00, cab_o});
            rd_reg(PRC_ADDR_RX_CONTROL_A);
            chk("ctrl readback", v, rv & 8'h2F);
        end
        $display("test control done");
        wr_reg(PRC_ADDR_RX_CONTROL_A, 8'h01);
        frame(2'h2, 8'd6, 1'b1);
        frame(2'h3, 8'd6, 1'b1);
        rd_reg(PRC_ADDR_IRQ_STAT);
        chk("reset before enable", 8'h00, rv & 8'h06);
        frame(2'h0, 8'd20, 1'b0);
        cyc(2);
        wr_reg(PRC_ADDR_RX_CONTROL_A, 8'h10);
        cyc(2);
        chk("enable deferred", 8'h00, {7'h00, rx_act});
        cyc(22);
        chk("enable applied", 8'h01, {7'h00, rx_act});
        chk("allow set", 8'h01, {7'h00, allow});
        prot_rst <= 1'b1;
        cyc(3);
        chk("enable kept", 8'h01, {7'h00, rx_act});
        chk("queue held", 8'h01, {7'h00, q_rst});
        prot_rst <= 1'b0;
        cyc(3);
        chk("queue free", 8'h00, {7'h00, q_rst});
        frame(2'h2, 8'd6, 1'b1);
        chk("hard clears en", 8'h00, {7'h00, rx_act});
        wr_reg(PRC_ADDR_IRQ_STAT, 8'h07);
        frame(2'h3, 8'd6, 1'b1);
        rd_reg(PRC_ADDR_IRQ_STAT);
        chk("cable ignored", 8'h00, rv & 8'h04);
        wr_reg(PRC_ADDR_RX_CONTROL_A, 8'h01);
        frame(2'h3, 8'd6, 1'b1);
        rd_reg(PRC_ADDR_IRQ_STAT);
        chk("cable seen", 8'h04, rv & 8'h04);
        chk("cable det armed", 8'h01, {7'h00, cab_o});
        sw_rst <= 1'b1;
        cyc(2);
        sw_rst <= 1'b0;
        cyc(2);
        chk("allow cleared", 8'h00, {7'h00, allow});
        $display("test receive done");
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 0 : $urandom_range(1, 6);
            wr_reg(PRC_ADDR_PD_DELAY, 8'(d));
            tx_frame();
            n = 0;
            while (n < 100)
            begin
                cyc(1);
                if (pwr !== 1'b1)
                    break;
                n++;
            end
            chk("power hold", 8'(pd_clks(d)), 8'(n));
        end
        tx_frame();
        tx_req <= 1'b1;
        cyc(pd_clks(d) + 8);
        chk("power kept", 8'h01, {7'h00, pwr});
        tx_req <= 1'b0;
        tx_frame();
        cyc(pd_clks(d) + 10);
        chk("power off", 8'h00, {7'h00, pwr});
        $display("test power done");
        wr_reg(PRC_ADDR_TMR_LOAD, 8'h00);
        wr_reg(PRC_ADDR_IRQ_MASK, 8'h00);
        e = tmo_clks(0);
        foreach (tc[i])
        begin
            wr_reg(PRC_ADDR_IRQ_STAT, 8'h07);
            wr_reg(PRC_ADDR_RX_CONTROL_A, {5'h00, tc[i][4], 2'h0});
            auto_rsp  <= tc[i][3];
            wait_ack  <= tc[i][2];
            retry     <= {1'b0, tc[i][1:0]};
            test_mode <= (i == 0);
            tx_frame();
            cyc(e - 3);
            chk("early timeout", 8'h00, {7'h00, tmo});
            cyc(8);
            v = {7'h00, tmr_on(tc[i])};
            chk("timeout", v, {7'h00, tmo});
            chk("irq level", v, {7'h00, irq});
        end
        rd_reg(PRC_ADDR_STATUS);
        chk("reloaded", 8'h00, rv & 8'h02);
        {auto_rsp, wait_ack, retry, test_mode} <= '0;
        wr_reg(PRC_ADDR_IRQ_STAT, 8'h07);
        wr_reg(PRC_ADDR_RX_CONTROL_A, 8'h04);
        tx_frame();
        frame(2'h1, 8'd4, 1'b1);
        wr_reg(PRC_ADDR_RX_CONTROL_A, 8'h00);
        cyc(e + 5);
        chk("acked", 8'h00, {7'h00, tmo});
        wr_reg(PRC_ADDR_IRQ_MASK, 8'h01);
        wr_reg(PRC_ADDR_RX_CONTROL_A, 8'h04);
        tx_frame();
        cyc(e + 5);
        chk("masked flag", 8'h01, {7'h00, tmo});
        chk("masked irq", 8'h00, {7'h00, irq});
        rd_reg(PRC_ADDR_STATUS);
        chk("stays expired", 8'h02, rv & 8'h02);
        wr_reg(PRC_ADDR_IRQ_MASK, 8'h00);
        cyc(2);
        chk("unmasked irq", 8'h01, {7'h00, irq});
        wr_reg(PRC_ADDR_IRQ_STAT, 8'h01);
        cyc(2);
        chk("cleared irq", 8'h00, {7'h00, irq});
        $display("test timer done");
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        err_total++;
        conclude();
    end
endmodule // prc_rx_control_tb
`default_nettype wire
